// ===== rtl/sdes_axil.sv
// AXI4-Lite slave holding the control word and reading back status
`timescale 1ns/1ps
module sdes_axil
	import sdes_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [4:0] status,
	input wire logic [17:0] rx_word,
	output logic [4:0] ctrl
);
	logic [3:0] awaddr_q; // Captured write address
	logic aw_have_q; // Address held
	logic [7:0] wbyte_q; // Low byte of captured data
	logic wstrb0_q; // Lane 0 strobe
	logic w_have_q; // Data held
	logic [4:0] ctrl_q; // Control register
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;

	// Take each half while not yet held and no response waits
	assign s_axi_awready = ~aw_have_q & ~bvalid_q;
	assign s_axi_wready = ~w_have_q & ~bvalid_q;
	wire do_write = aw_have_q & w_have_q;
	wire wr_ctrl = do_write & (awaddr_q == CTRL_ADDR);
	wire wr_known = (awaddr_q == CTRL_ADDR) | (awaddr_q == STATUS_ADDR)
		| (awaddr_q == RXDATA_ADDR);
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign ctrl = ctrl_q;

	// Write path: either order, response after both
	always_ff @(posedge aclk)
	begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 4'h0;
			wbyte_q <= 8'h00;
			wstrb0_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			ctrl_q <= CTRL_RESET;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				wbyte_q <= s_axi_wdata[7:0];
				wstrb0_q <= s_axi_wstrb[0];
			end
			if (do_write) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
			// Status and data words are read-only; writes there are dropped
			if (wr_ctrl && wstrb0_q)
				ctrl_q <= wbyte_q[4:0];
		end
	end

	// Read path: one read at a time, data from a register
	assign s_axi_arready = ~rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	wire [31:0] rd_mux = (s_axi_araddr == CTRL_ADDR) ? {27'h0, ctrl_q}
		: (s_axi_araddr == STATUS_ADDR) ? {27'h0, status}
		: (s_axi_araddr == RXDATA_ADDR) ? {14'h0, rx_word} : 32'h0;
	wire rd_known = (s_axi_araddr == CTRL_ADDR) | (s_axi_araddr == STATUS_ADDR)
		| (s_axi_araddr == RXDATA_ADDR);
	always_ff @(posedge aclk)
	begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_mux;
			rresp_q <= rd_known ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end
endmodule : sdes_axil

// ===== rtl/sdes_pkg.sv
// Shared constants for the 18-bit embedded-clock serializer/deserializer
package sdes_pkg;
	// Clock period of aclk
	localparam int CLK_PERIOD_NS = 4;
	// Frame layout: start bit, 18 data bits, stop bit
	localparam int WORD_BITS = 18;
	localparam int FRAME_BITS = 20;
	localparam logic START_BIT = 1'b1;
	localparam logic STOP_BIT = 1'b0;
	// Last bit slot of a frame
	localparam logic [4:0] LAST_SLOT = 5'h13;
	// Half a frame, for the recovered clock duty
	localparam logic [4:0] HALF_SLOT = 5'h0a;
	// Alignment word: nine ones then nine zeros, ones sent first
	localparam logic [17:0] ALIGN_WORD = 18'h3fe00;
	// Word clocks of held request before alignment words replace data
	localparam logic [2:0] SYNC_HOLD_WORDS = 3'h6;
	// Consecutive missing clock edges that drop lock
	localparam logic [1:0] MISS_LIMIT = 2'h2;
	// Default PLL settle times, in word clocks
	localparam int TX_LOCK_WORDS = 4;
	localparam int RX_REF_LOCK_WORDS = 4;
	// Frames a single edge candidate must persist during a hunt
	localparam int HUNT_FRAMES = 2;
	// Register byte addresses
	localparam logic [3:0] CTRL_ADDR = 4'h0;
	localparam logic [3:0] STATUS_ADDR = 4'h4;
	localparam logic [3:0] RXDATA_ADDR = 4'h8;
	// Control fields
	localparam int CTRL_TX_SLEEP_N = 0;
	localparam int CTRL_TX_LINE_EN = 1;
	localparam int CTRL_TX_SYNC = 2;
	localparam int CTRL_RX_SLEEP_N = 3;
	localparam int CTRL_RX_OUT_EN = 4;
	localparam logic [4:0] CTRL_RESET = 5'h00;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Receiver states
	typedef enum logic [1:0] {RX_REFLOCK, RX_HUNT, RX_LOCKED} sdes_rx_state_t;
endpackage : sdes_pkg

// ===== rtl/sdes_tick.sv
// Bit and word rate enable generator for one half of the link
`timescale 1ns/1ps
module sdes_tick
	import sdes_pkg::*;
#(
	parameter int DIV = 1
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	output logic bit_tick,
	output logic word_tick,
	output logic [4:0] slot
);
	localparam int DW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);

	// Reject a divider that cannot make a pulse
	if (DIV < 1) begin : g_bad_div
		$error("sdes_tick: DIV must be at least 1");
	end

	logic [DW-1:0] div_q; // Cycles within one bit
	logic [4:0] slot_q; // Bit slot within the frame
	wire div_end = (div_q == DIV_LAST);

	assign bit_tick = run & div_end;
	// Word edge is the first slot of each frame
	assign word_tick = bit_tick & (slot_q == 5'h00);
	assign slot = slot_q;

	// Divider stops while asleep so no stray edges appear
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !run) begin
			div_q <= '0;
			slot_q <= 5'h00;
		end else begin
			div_q <= div_end ? '0 : div_q + DW'(1);
			if (div_end)
				slot_q <= (slot_q == LAST_SLOT) ? 5'h00 : slot_q + 5'h01;
		end
	end
endmodule : sdes_tick

// ===== rtl/sdes_top.sv
// Serializer and deserializer halves with their register slave
//
// How it works
// - Frame: start bit one, stop bit zero
// - Twenty serial bits per word clock
// - Capture parallel word at each word edge
// - Six held requests send alignment words instead
// - Serial output off until transmit lock
// - Receive outputs off during reference lock, lock high
// - Find start edge in alignment or random data
// - Far side sends random data or alignment
// - Lock low with first valid word
// - Recovered clock follows word, valid while locked
// - Two missed edges drop lock, hunt again
// - Several persisting edge candidates refuse lock
// - Receive sleep stops and floats outputs
// - Receive wake restarts initialization
// - Transmit sleep stops and floats serial output
// - Transmit wake relocks before sending
// - Receive enable floats data and clock
// - Line enable floats serial output
// - Halves run independently
// - Alignment word nine ones, nine zeros
`timescale 1ns/1ps
module sdes_top
	import sdes_pkg::*;
#(
	parameter int TX_BIT_DIV = 1,
	parameter int RX_BIT_DIV = 1,
	parameter int TX_LOCK = TX_LOCK_WORDS,
	parameter int RX_LOCK = RX_REF_LOCK_WORDS
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [17:0] tx_parallel_in,
	output logic serial_out,
	output logic serial_oe,
	input wire logic serial_in,
	output logic [17:0] rx_parallel_out,
	output logic rx_parallel_oe,
	output logic rx_recovered_clock,
	output logic rx_recovered_clock_oe,
	output logic rx_lock_n
);
	// Elaboration checks on settle counts
	if (TX_LOCK < 1 || TX_LOCK > 255 || RX_LOCK < 1 || RX_LOCK > 255) begin : g_bad_lock
		$error("sdes_top: lock counts must lie in 1..255");
	end

	logic [4:0] ctrl; // Software control bits
	logic [4:0] status; // Readback of block state

	wire tx_sleep_n = ctrl[CTRL_TX_SLEEP_N];
	wire tx_line_enable = ctrl[CTRL_TX_LINE_EN];
	wire tx_sync_request = ctrl[CTRL_TX_SYNC];
	wire rx_sleep_n = ctrl[CTRL_RX_SLEEP_N];
	wire rx_out_enable = ctrl[CTRL_RX_OUT_EN];

	// Register slave
	sdes_axil u_regs (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.status(status),
		.rx_word(rx_parallel_out),
		.ctrl(ctrl)
	);

	// Transmit half

	logic tx_bit_tick; // One serial bit time
	logic tx_word_clock; // Word clock edge, one pulse per frame
	logic [4:0] tx_slot; // Bit slot of the frame being sent

	// Own divider, stopped in sleep like the PLL
	sdes_tick #(.DIV(TX_BIT_DIV)) u_tx_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(tx_sleep_n),
		.bit_tick(tx_bit_tick),
		.word_tick(tx_word_clock),
		.slot(tx_slot)
	);

	logic [7:0] tx_lock_cnt_q; // Word clocks seen since wake
	logic tx_locked_q; // Transmit PLL settled
	logic [2:0] sync_cnt_q; // Word clocks with request held
	logic [19:0] tx_shift_q; // Bits of the frame still to go
	logic tx_bit_q; // Serial line level
	logic [17:0] tx_word_q; // Word carried by current frame

	wire sync_active = (sync_cnt_q == SYNC_HOLD_WORDS);
	// Alignment words take the place of captured data
	wire [17:0] tx_word_d = sync_active ? ALIGN_WORD : tx_parallel_in;
	wire [19:0] tx_frame_d = {START_BIT, tx_word_d, STOP_BIT};

	// Settle counter; sleep stops it so wake must relock
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !tx_sleep_n) begin
			tx_lock_cnt_q <= 8'h00;
			tx_locked_q <= 1'b0;
		end else if (tx_word_clock && !tx_locked_q) begin
			tx_lock_cnt_q <= tx_lock_cnt_q + 8'h01;
			tx_locked_q <= (tx_lock_cnt_q == 8'(TX_LOCK - 1));
		end
	end

	// Request count saturates; after a drop one more alignment word goes out, then data resumes
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !tx_sleep_n)
			sync_cnt_q <= 3'h0;
		else if (tx_word_clock)
			sync_cnt_q <= !tx_sync_request ? 3'h0 :
				(sync_active ? sync_cnt_q : sync_cnt_q + 3'h1);
	end

	// Frame shifter, start bit first, one bit per bit time
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !tx_locked_q) begin
			tx_shift_q <= 20'h0;
			tx_bit_q <= 1'b0;
			tx_word_q <= 18'h0;
		end else if (tx_word_clock) begin
			tx_bit_q <= tx_frame_d[19];
			tx_shift_q <= {tx_frame_d[18:0], 1'b0};
			tx_word_q <= tx_word_d;
		end else if (tx_bit_tick) begin
			tx_bit_q <= tx_shift_q[19];
			tx_shift_q <= {tx_shift_q[18:0], 1'b0};
		end
	end

	// Line enable only gates the driver, so the frame keeps running
	assign serial_out = tx_bit_q;
	assign serial_oe = tx_locked_q & tx_sleep_n & tx_line_enable;

	// Receive half

	logic rx_bit_tick; // One serial bit time
	logic rx_word_tick; // Reference frame start
	logic [4:0] rx_slot; // Bit slot counted from reference

	sdes_tick #(.DIV(RX_BIT_DIV)) u_rx_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(rx_sleep_n),
		.bit_tick(rx_bit_tick),
		.word_tick(rx_word_tick),
		.slot(rx_slot)
	);

	sdes_rx_state_t rx_state_q; // Receiver phase
	logic [7:0] ref_cnt_q; // Reference word clocks since wake
	logic [18:0] rx_hist_q; // Last nineteen serial bits
	logic [19:0] seen_q; // Slots that framed this frame
	logic [19:0] persist_q; // Slots that framed every frame so far
	logic [7:0] hunt_cnt_q; // Frames in the current hunt
	logic [4:0] phase_q; // Slot where frames end
	logic [1:0] miss_q; // Consecutive missing edges
	logic lock_n_q; // Lock indicator, low when locked
	logic rmt_q; // Repeated multi-edge pattern seen
	logic [17:0] rx_word_q; // Last good word
	logic [4:0] rel_q; // Slots since frame end
	logic rclk_q; // Recovered clock level

	// Window ending at the bit now arriving
	wire [19:0] win = {rx_hist_q, serial_in};
	// Start bit nineteen bits back and stop bit arriving now frame a whole word
	wire frame_ok = (win[19] == START_BIT) & (win[0] == STOP_BIT);
	wire [19:0] seen_d = seen_q | ({19'h0, frame_ok} << rx_slot);
	wire [19:0] persist_d = persist_q & seen_d;
	wire hunt_end = rx_bit_tick & (rx_slot == LAST_SLOT)
		& (hunt_cnt_q == 8'(HUNT_FRAMES - 1));
	wire phase_tick = rx_bit_tick & (rx_slot == phase_q);

	// Count and locate surviving candidates
	logic [4:0] cand_cnt;
	logic [4:0] cand_idx;
	always_comb
	begin
		cand_cnt = 5'h00;
		cand_idx = 5'h00;
		for (int i = 0; i < FRAME_BITS; i++) begin
			if (persist_d[i]) begin
				cand_cnt = cand_cnt + 5'h01;
				cand_idx = 5'(i);
			end
		end
	end

	// History shift; ignored line during sleep
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !rx_sleep_n)
			rx_hist_q <= 19'h0;
		else if (rx_bit_tick)
			rx_hist_q <= win[18:0];
	end

	// Receiver sequence: reference lock, hunt, locked
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !rx_sleep_n) begin
			rx_state_q <= RX_REFLOCK;
			ref_cnt_q <= 8'h00;
			seen_q <= 20'h0;
			persist_q <= '1;
			hunt_cnt_q <= 8'h00;
			phase_q <= 5'h00;
			miss_q <= 2'h0;
			lock_n_q <= 1'b1;
			rmt_q <= 1'b0;
			rx_word_q <= 18'h0;
		end else begin
			case (rx_state_q)
				RX_REFLOCK:
				begin
					// Settle to the reference before looking at the line
					if (rx_word_tick) begin
						ref_cnt_q <= ref_cnt_q + 8'h01;
						if (ref_cnt_q == 8'(RX_LOCK - 1))
							rx_state_q <= RX_HUNT;
					end
				end
				RX_HUNT:
				begin
					// Keep only slots that framed in every frame
					if (rx_bit_tick) begin
						seen_q <= (rx_slot == LAST_SLOT) ? 20'h0 : seen_d;
						if (rx_slot == LAST_SLOT) begin
							persist_q <= hunt_end ? '1 : persist_d;
							hunt_cnt_q <= hunt_end ? 8'h00 : hunt_cnt_q + 8'h01;
						end
					end
					if (hunt_end) begin
						if (cand_cnt == 5'h01) begin
							phase_q <= cand_idx;
							miss_q <= 2'h0;
							rx_state_q <= RX_LOCKED;
						end else begin
							// No single position: keep searching, lock stays high
							rmt_q <= (cand_cnt > 5'h01);
						end
					end
				end
				RX_LOCKED:
				begin
					if (phase_tick && frame_ok) begin
						// Word and lock indicator move in the same cycle
						rx_word_q <= win[18:1];
						lock_n_q <= 1'b0;
						rmt_q <= 1'b0;
						miss_q <= 2'h0;
					end else if (phase_tick) begin
						miss_q <= miss_q + 2'h1;
						if (miss_q == MISS_LIMIT - 2'h1) begin
							// Restart the search on whatever arrives
							lock_n_q <= 1'b1;
							rx_state_q <= RX_HUNT;
							seen_q <= 20'h0;
							persist_q <= '1;
							hunt_cnt_q <= 8'h00;
						end
					end
				end
				default:
				begin
					rx_state_q <= RX_REFLOCK;
				end
			endcase
		end
	end

	// Recovered clock: high for the first half of each frame
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !rx_sleep_n || rx_state_q != RX_LOCKED) begin
			rel_q <= 5'h00;
			rclk_q <= 1'b0;
		end else if (phase_tick) begin
			rel_q <= 5'h01;
			rclk_q <= 1'b1;
		end else if (rx_bit_tick) begin
			rel_q <= rel_q + 5'h01;
			// Slot count equals half a frame here, so high and low are ten each
			if (rel_q == HALF_SLOT)
				rclk_q <= 1'b0;
		end
	end

	// Enable only gates drivers, so restoring it shows the prior state
	wire rx_drive = rx_sleep_n & rx_out_enable & (rx_state_q != RX_REFLOCK);
	assign rx_parallel_out = rx_word_q;
	assign rx_parallel_oe = rx_drive;
	assign rx_recovered_clock = rclk_q;
	assign rx_recovered_clock_oe = rx_drive;
	assign rx_lock_n = lock_n_q;
	assign status = {rmt_q, lock_n_q, rx_state_q != RX_REFLOCK, sync_active, tx_locked_q};

	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_tx_start_bit: assert property (tx_word_clock && tx_locked_q |=> serial_out == START_BIT)
		else $error("start bit not one");
	a_tx_stop_bit: assert property (tx_bit_tick && tx_locked_q && !tx_word_clock
		&& tx_slot == LAST_SLOT |=> serial_out == STOP_BIT)
		else $error("stop bit not zero");
	a_tx_capture: assert property (tx_word_clock && tx_locked_q && !sync_active
		|=> tx_word_q == $past(tx_parallel_in))
		else $error("parallel word not captured");
	a_tx_align_word: assert property (tx_word_clock && tx_locked_q && sync_active
		|=> tx_word_q == 18'h3fe00)
		else $error("alignment word wrong");
	a_tx_sync_hold: assert property (tx_word_clock && !sync_active && sync_cnt_q == 3'h5
		&& tx_sync_request |=> sync_active)
		else $error("request hold count wrong");
	a_tx_hiz_unlock: assert property (!tx_locked_q |-> !serial_oe)
		else $error("serial driven before lock");
	a_tx_sleep_relock: assert property ($rose(tx_sleep_n) |-> !tx_locked_q [*2])
		else $error("no relock after wake");
	a_rx_init_hiz: assert property (rx_state_q == RX_REFLOCK |-> !rx_parallel_oe && rx_lock_n)
		else $error("outputs driven during reference lock");
	a_rx_lock_data: assert property ($fell(rx_lock_n) |-> rx_parallel_out == $past(win[18:1]))
		else $error("lock and data not together");
	a_rx_two_miss: assert property (rx_state_q == RX_LOCKED && phase_tick && !frame_ok
		&& miss_q == 2'h1 |=> rx_lock_n && rx_state_q == RX_HUNT)
		else $error("two misses did not drop lock");
	a_rx_one_miss: assert property (rx_state_q == RX_LOCKED && phase_tick && !frame_ok
		&& miss_q == 2'h0 |=> rx_state_q == RX_LOCKED)
		else $error("single miss dropped lock");
	a_rx_miss_clear: assert property (rx_state_q == RX_LOCKED && phase_tick && frame_ok
		|=> miss_q == 2'h0)
		else $error("good edge left miss count");
	a_rx_rmt_refuse: assert property (rmt_q |-> rx_lock_n)
		else $error("locked on repetitive pattern");
	a_rx_sleep_hiz: assert property (!rx_sleep_n |=> !rx_parallel_oe && !rx_recovered_clock_oe
		&& rx_state_q == RX_REFLOCK)
		else $error("sleep did not float outputs");

	c_rx_lock: cover property ($fell(rx_lock_n));
	c_rx_lock_loss: cover property ($rose(rx_lock_n));
	c_rx_rmt: cover property ($rose(rmt_q));
	c_tx_align: cover property ($rose(sync_active));
endmodule : sdes_top

// ===== testbench/sdes_far_end.sv
// Far-end serializer model driving the receive serial input
`timescale 1ns/1ps
module sdes_far_end
	import sdes_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic en,
	input wire logic align,
	input wire logic brk,
	input wire logic [17:0] word,
	output logic frame_go,
	output logic serial_line
);
	// Bit slot within the frame
	logic [4:0] slot_q;
	// Bits still to be sent
	logic [19:0] sh_q;
	// Next frame: a broken frame drops its start bit
	logic [19:0] frame_w;
	assign frame_w = {brk ? 1'b0 : START_BIT, align ? ALIGN_WORD : word, STOP_BIT};
	// Load slot for the bench
	assign frame_go = en && (slot_q == 5'h00);
	// One bit per clock, frames back to back
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			slot_q <= 5'h00;
			serial_line <= 1'b0;
		end
		else if (!en)
		begin
			// Released line keeps changing so no stale level reads as data
			slot_q <= 5'h00;
			serial_line <= !serial_line;
		end
		else
		begin
			slot_q <= (slot_q == LAST_SLOT) ? 5'h00 : slot_q + 5'h01;
			serial_line <= (slot_q == 5'h00) ? frame_w[19] : sh_q[19];
			sh_q <= (slot_q == 5'h00) ? {frame_w[18:0], 1'b0} : {sh_q[18:0], 1'b0};
		end
	end
endmodule : sdes_far_end

// ===== testbench/testbench.sv
// Self-checking bench for the serializer and deserializer block
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
	$display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module testbench
	import sdes_pkg::*;
;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [17:0] tx_parallel_in, rx_parallel_out;
	logic serial_out, serial_oe, serial_in, rx_parallel_oe, rx_recovered_clock;
	logic rx_recovered_clock_oe, rx_lock_n;
	// Far-end controls
	logic f_en, f_align, f_brk, frame_go;
	logic [17:0] f_word;
	// Last twenty bits seen on the serial output
	logic [19:0] win;
	logic [4:0] hi;
	// Random word handed to a driver and kept for the model
	logic [17:0] tw;
	// Words the far end sent, newest last
	logic [17:0] sent[$];
	int errors, compares, cycles, seed;
	sdes_top #(.TX_LOCK(2), .RX_LOCK(2)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .tx_parallel_in(tx_parallel_in),
		.serial_out(serial_out), .serial_oe(serial_oe), .serial_in(serial_in),
		.rx_parallel_out(rx_parallel_out), .rx_parallel_oe(rx_parallel_oe),
		.rx_recovered_clock(rx_recovered_clock), .rx_recovered_clock_oe(rx_recovered_clock_oe),
		.rx_lock_n(rx_lock_n));
	sdes_far_end far (.aclk(aclk), .aresetn(aresetn), .en(f_en), .align(f_align), .brk(f_brk),
		.word(f_word), .frame_go(frame_go), .serial_line(serial_in));
	// Free-running clock
	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// Serial window and watchdog; ceiling well above the expected run
	always @(posedge aclk)
	begin
		win <= {win[18:0], serial_out};
		cycles++;
		if (cycles == 40000)
		begin
			errors++;
			complete_run();
		end
	end
	// Verdict and end of run
	task complete_run();
		if (errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	// Register write; both halves offered together
	task wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] resp);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	// Register read
	task rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	// Find a whole frame of w, then the same frame one frame later
	task tx_frame(input logic [17:0] w, input int lim);
		int i;
		for (i = 0; i < lim; i++)
		begin
			@(posedge aclk);
			if (serial_oe === 1'b1 && win === {START_BIT, w, STOP_BIT}) break;
		end
		`CHK(win, {START_BIT, w, STOP_BIT})
		repeat (20) @(posedge aclk);
		`CHK(win, {START_BIT, w, STOP_BIT})
	endtask : tx_frame
	// Bounded wait for a lock level
	task wait_lock(input logic want, input int lim);
		int i;
		for (i = 0; i < lim && rx_lock_n !== want; i++) @(posedge aclk);
		`CHK(rx_lock_n, want)
	endtask : wait_lock
	// Send n frames without their start edge
	task brk_frames(input int n);
		@(posedge aclk iff frame_go);
		f_brk <= 1'b1;
		repeat (n) @(posedge aclk iff frame_go);
		f_brk <= 1'b0;
	endtask : brk_frames
	// Main sequence
	initial
	begin
		seed = 40;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
		s_axi_wstrb = 4'hf;
		{f_en, f_align, f_brk, f_word} = 21'h0;
		tx_parallel_in = 18'h0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		`CHK(serial_oe, 1'b0)
		`CHK(rx_lock_n, 1'b1)
		rd(CTRL_ADDR, d, r);
		`CHK(d, 32'h0)
		wr(4'hc, 32'h1f, r);
		`CHK(r, RESP_SLVERR)
		rd(4'hc, d, r);
		`CHK(r, RESP_SLVERR)
		// Far end sends alignment words while we are unlocked
		f_en <= 1'b1;
		f_align <= 1'b1;
		tx_parallel_in <= 18'($random(seed));
		wr(CTRL_ADDR, 32'h1b, r);
		`CHK(r, RESP_OKAY)
		`CHK(serial_oe, 1'b0)
		`CHK(rx_parallel_oe, 1'b0)
		tx_frame(tx_parallel_in, 400);
		tw = 18'($random(seed));
		tx_parallel_in <= tw;
		tx_frame(tw, 100);
		wr(CTRL_ADDR, 32'h1f, r);
		tx_frame(ALIGN_WORD, 200);
		wr(CTRL_ADDR, 32'h1b, r);
		wait_lock(1'b0, 1500);
		`CHK(rx_parallel_out, ALIGN_WORD)
		`CHK(rx_recovered_clock_oe, 1'b1)
		hi = 5'h00;
		repeat (20) @(posedge aclk) hi = hi + rx_recovered_clock;
		`CHK(hi, 5'h0a)
		// Random data through the locked receiver
		tw = 18'($random(seed));
		f_word <= tw;
		f_align <= 1'b0;
		sent.push_back(tw);
		repeat (70) @(posedge aclk);
		`CHK(rx_parallel_out, sent[$])
		rd(RXDATA_ADDR, d, r);
		`CHK(d, {14'h0, sent[$]})
		wr(CTRL_ADDR, 32'h18, r);
		repeat (2) @(posedge aclk);
		`CHK(serial_oe, 1'b0)
		`CHK(rx_lock_n, 1'b0)
		brk_frames(1);
		repeat (60) @(posedge aclk);
		`CHK(rx_lock_n, 1'b0)
		brk_frames(2);
		wait_lock(1'b1, 60);
		`CHK(rx_parallel_out, sent[$])
		// Far end switches to alignment words after the lock loss
		f_align <= 1'b1;
		wait_lock(1'b0, 1500);
		wr(CTRL_ADDR, 32'h0b, r);
		repeat (2) @(posedge aclk);
		`CHK({rx_parallel_oe, rx_recovered_clock_oe}, 2'h0)
		wr(CTRL_ADDR, 32'h1b, r);
		repeat (2) @(posedge aclk);
		`CHK({rx_parallel_oe, rx_recovered_clock_oe}, 2'h3)
		tx_frame(tx_parallel_in, 400);
		wr(CTRL_ADDR, 32'h19, r);
		repeat (2) @(posedge aclk);
		`CHK(serial_oe, 1'b0)
		wr(CTRL_ADDR, 32'h1b, r);
		tx_frame(tx_parallel_in, 100);
		// Receiver sleep, then wake into a repetitive pattern
		wr(CTRL_ADDR, 32'h13, r);
		repeat (2) @(posedge aclk);
		`CHK({rx_parallel_oe, rx_lock_n}, 2'h1)
		f_align <= 1'b0;
		f_word <= 18'h2aaaa;
		wr(CTRL_ADDR, 32'h1b, r);
		repeat (600) @(posedge aclk);
		`CHK(rx_lock_n, 1'b1)
		rd(STATUS_ADDR, d, r);
		`CHK(d[4], 1'b1)
		f_align <= 1'b1;
		wait_lock(1'b0, 1500);
		complete_run();
	end
endmodule : testbench
